// ===== rtl/idf_pkg.sv
// Overview of operation
// - a point changes state only after the new level held for the filter time
// - a level that reverts before the filter time ends is discarded silently
// - timestamps are taken only for transitions that passed the filter
// - event and plain transitions go through the same filter
// - each point has separate off-to-on and on-to-off filter times
// - configured flag stays set until module reset or power cycle
// - owned flag is true only while an owner connection exists
// - reset request returns the module to power-up state, closing connections
// - major and minor fault shown, cause memory fault, backplane fault or none
// - fault and status data are sent together with point data
package idf_pkg;
  localparam int NUM_POINTS = 16;
  localparam int ADDR_W = 8;
  localparam int FT_W = 16;
  // timebase: filter times and timestamps count microseconds
  localparam int CLK_MHZ = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ) / 1000;
  localparam int STARTUP_CYCLES = 2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_POINTS = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_TIME = 8'h14;
  localparam logic [7:0] OFS_FILT_BASE = 8'h40;
  localparam logic [7:0] OFS_TS_BASE = 8'h80;
  // control bits
  localparam int CTRL_CONFIG_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  // status bits
  localparam int ST_CONFIGURED = 0;
  localparam int ST_OWNED = 1;
  localparam int ST_MAJOR = 2;
  localparam int ST_MINOR = 3;
  localparam int ST_CAUSE_LO = 4;
  localparam int ST_W = 6;
  // fault cause codes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_NVM = 2'h1;
  localparam logic [1:0] CAUSE_BKPL = 2'h2;
  // reset values
  localparam logic [31:0] FILT_RESET = 32'h0000_0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
endpackage

// ===== rtl/idf_point_filter.sv
`timescale 1ns/100ps
module idf_point_filter #(
  parameter int FT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic prime,
  input wire logic us_tick,
  input wire logic [FT_W-1:0] t_on,
  input wire logic [FT_W-1:0] t_off,
  // sampled level and result
  input wire logic sample,
  output logic state,
  output logic accept
);
  logic [FT_W-1:0] cnt;
  logic [FT_W-1:0] limit;

  assign limit = state ? t_off : t_on;

  // qualification counter and reported state
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= 1'b0;
      cnt <= '0;
      accept <= 1'b0;
    end else if (prime) begin
      state <= sample;
      cnt <= '0;
      accept <= 1'b0;
    end else if (sample == state) begin
      cnt <= '0;
      accept <= 1'b0;
    end else if ((limit == '0) || ((cnt >= limit) && us_tick)) begin
      // the first tick may come at once, so wait one tick past the limit
      state <= sample;
      cnt <= '0;
      accept <= 1'b1;
    end else begin
      // saturates at the limit, so a held level never wraps
      if (us_tick) begin
        cnt <= cnt + 1'b1;
      end
      accept <= 1'b0;
    end
  end
endmodule

// ===== rtl/idf_top.sv
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module idf_top
  import idf_pkg::*;
#(
  parameter int NPTS = idf_pkg::NUM_POINTS
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [idf_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // field inputs and backplane status pins
  input wire logic [NPTS-1:0] IN_RAW,
  input wire logic OWNER_CONN,
  input wire logic NVM_FAULT,
  input wire logic BKPL_FAULT,
  // point data and multicast
  output logic [NPTS-1:0] POINT_STATE,
  output logic MCAST_VALID,
  output logic [NPTS-1:0] MCAST_POINTS,
  output logic [idf_pkg::ST_W-1:0] MCAST_STATUS,
  // module status
  output logic CONFIGURED,
  output logic OWNED,
  output logic CONN_CLOSE,
  output logic IRQ
);
  import idf_pkg::*;

  // startup sequence: let the synchronisers fill, prime once, then run
  typedef enum logic [2:0] {
    boot_fill = 3'b001,
    boot_prime = 3'b010,
    boot_run = 3'b100
  } idf_boot_t;

  idf_boot_t boot, next_boot;
  logic soft_rst;
  logic rst;
  logic [NPTS-1:0] raw_s1, raw_s2;
  logic [2:0] pin_s1, pin_s2;
  logic [1:0] init_cnt;
  logic prime;
  logic [7:0] tick_cnt;
  logic us_tick;
  logic [31:0] time_us;
  logic [31:0] filt [NPTS];
  logic [31:0] stamp [NPTS];
  logic [NPTS-1:0] filt_state, accept;
  logic [NPTS-1:0] int_status, int_mask;
  logic [ST_W-1:0] status, status_q;
  logic configured;
  logic access, wr_en;
  logic [31:0] next_rdata;
  logic next_slverr;

  // index of a per-point window, used by read and write decode
  function automatic logic [3:0] pt_idx(input logic [ADDR_W-1:0] a);
    pt_idx = a[5:2];
  endfunction

  // true when the address falls in a 16-word window at base
  function automatic logic in_win(input logic [ADDR_W-1:0] a, input logic [7:0] base);
    in_win = (a[7:6] == base[7:6]) && (a[1:0] == 2'h0);
  endfunction

  // reset request acts like a power cycle
  assign rst = !RESET_N || soft_rst;
  assign access = PSEL && PENABLE && !PREADY;
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

  // reset request pulse; survives only its own cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_en && (PADDR == OFS_CTRL) && PWDATA[CTRL_RESET_BIT];
    end
  end

  // two-flop synchronisers for field and backplane pins
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      raw_s1 <= '0;
      raw_s2 <= '0;
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      raw_s1 <= IN_RAW;
      raw_s2 <= raw_s1;
      pin_s1 <= {BKPL_FAULT, NVM_FAULT, OWNER_CONN};
      pin_s2 <= pin_s1;
    end
  end

  // startup state and fill counter
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      init_cnt <= 2'h0;
      boot <= boot_fill;
    end else begin
      boot <= next_boot;
      if (boot == boot_fill) begin
        init_cnt <= init_cnt + 2'h1;
      end
    end
  end

  // prime once the synchronisers hold real pin levels
  always_comb begin
    next_boot = boot;
    case (boot)
      boot_fill: begin
        if (init_cnt == 2'(STARTUP_CYCLES - 1)) begin
          next_boot = boot_prime;
        end
      end
      boot_prime: begin
        next_boot = boot_run;
      end
      boot_run: begin
        next_boot = boot_run;
      end
      default: begin
        next_boot = boot_fill;
      end
    endcase
  end

  // single prime pulse; a filter primed early would load reset zeros
  assign prime = (boot == boot_prime);

  // microsecond tick and running time for stamps
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      tick_cnt <= 8'h00;
      us_tick <= 1'b0;
      time_us <= 32'h0000_0000;
    end else begin
      us_tick <= (tick_cnt == 8'(TICK_CYCLES - 1));
      if (tick_cnt == 8'(TICK_CYCLES - 1)) begin
        tick_cnt <= 8'h00;
        time_us <= time_us + 32'h1;
      end else begin
        tick_cnt <= tick_cnt + 8'h1;
      end
    end
  end

  // one filter per point; no event path bypasses it
  for (genvar i = 0; i < NPTS; i++) begin : g_pt
    idf_point_filter #(.FT_W(FT_W)) u_filt (
      .clk(SYS_CLK),
      .rst(rst),
      .prime(prime),
      .us_tick(us_tick),
      .t_on(filt[i][FT_W-1:0]),
      .t_off(filt[i][16+FT_W-1:16]),
      .sample(raw_s2[i]),
      .state(filt_state[i]),
      .accept(accept[i])
    );
  end

  // per point filter times written by software
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      for (int i = 0; i < NPTS; i++) begin
        filt[i] <= FILT_RESET;
      end
    end else if (wr_en && in_win(PADDR, OFS_FILT_BASE)) begin
      filt[pt_idx(PADDR)] <= PWDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      for (int i = 0; i < NPTS; i++) begin
        stamp[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < NPTS; i++) begin
        if (accept[i]) begin
          stamp[i] <= time_us;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      configured <= 1'b0;
    end else if (wr_en && (PADDR == OFS_CTRL) && PWDATA[CTRL_CONFIG_BIT]) begin
      configured <= 1'b1;
    end
  end

  // owned follows the live connection; fault cause
  always_comb begin
    status = '0;
    status[ST_CONFIGURED] = configured;
    status[ST_OWNED] = pin_s2[0];
    status[ST_MAJOR] = pin_s2[1];
    status[ST_MINOR] = pin_s2[2];
    if (pin_s2[1]) begin
      status[ST_CAUSE_LO +: 2] = CAUSE_NVM;
    end else if (pin_s2[2]) begin
      status[ST_CAUSE_LO +: 2] = CAUSE_BKPL;
    end else begin
      status[ST_CAUSE_LO +: 2] = CAUSE_NONE;
    end
  end

  // sticky events, set wins over the write-one clear
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      int_status <= '0;
    end else if (wr_en && (PADDR == OFS_INT_STATUS)) begin
      int_status <= (int_status & ~PWDATA[NPTS-1:0]) | accept;
    end else begin
      int_status <= int_status | accept;
    end
  end

  // interrupt mask
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      int_mask <= MASK_RESET;
    end else if (wr_en && (PADDR == OFS_INT_MASK)) begin
      int_mask <= PWDATA[NPTS-1:0];
    end
  end

  // previous status word, to spot a change worth a frame
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= status;
    end
  end

  // a frame on every point change, status change or priming
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      MCAST_VALID <= 1'b0;
    end else begin
      MCAST_VALID <= (|accept) || (status != status_q) || prime;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      MCAST_POINTS <= '0;
    end else begin
      MCAST_POINTS <= filt_state;
    end
  end

  // status travels with the point data
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      MCAST_STATUS <= '0;
    end else begin
      MCAST_STATUS <= status;
    end
  end

  // filtered point states to the pins
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      POINT_STATE <= '0;
    end else begin
      POINT_STATE <= filt_state;
    end
  end

  // configured flag to its pin, one cycle behind the flag
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      CONFIGURED <= 1'b0;
    end else begin
      CONFIGURED <= configured;
    end
  end

  // connection dropped while the reset runs
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      OWNED <= 1'b0;
    end else begin
      OWNED <= status[ST_OWNED] && !soft_rst;
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_status & int_mask);
    end
  end

  // close pulse while the module resets
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      CONN_CLOSE <= 1'b0;
    end else begin
      CONN_CLOSE <= soft_rst;
    end
  end

  // read decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (in_win(PADDR, OFS_FILT_BASE)) begin
      next_rdata = filt[pt_idx(PADDR)];
    end else if (in_win(PADDR, OFS_TS_BASE)) begin
      next_rdata = stamp[pt_idx(PADDR)];
    end else begin
      case (PADDR)
        OFS_CTRL: next_rdata = 32'h0000_0000;
        OFS_STATUS: next_rdata[ST_W-1:0] = status;
        OFS_POINTS: next_rdata[NPTS-1:0] = filt_state;
        OFS_INT_STATUS: next_rdata[NPTS-1:0] = int_status;
        OFS_INT_MASK: next_rdata[NPTS-1:0] = int_mask;
        OFS_TIME: next_rdata = time_us;
        default: next_slverr = 1'b1;
      endcase
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge SYS_CLK) begin
    if (rst) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access;
      PSLVERR <= access && next_slverr;
      if (access && !PWRITE) begin
        PRDATA <= next_rdata;
      end
    end
  end
endmodule

// ===== bench/idf_asserts.sv
`timescale 1ns/100ps
module idf_asserts
  import idf_pkg::*;
#(
  parameter int NPTS = 16
) (
  // clock, reset, bus
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // status pins and data
  input wire logic OWNER_CONN,
  input wire logic NVM_FAULT,
  input wire logic [NPTS-1:0] POINT_STATE,
  input wire logic MCAST_VALID,
  input wire logic [NPTS-1:0] MCAST_POINTS,
  input wire logic [idf_pkg::ST_W-1:0] MCAST_STATUS,
  input wire logic CONFIGURED,
  input wire logic OWNED,
  input wire logic CONN_CLOSE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // bus answers: one cycle, only to an access
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
  chk_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("stray ready");
  chk_err_ready: assert property (PSLVERR |-> PREADY) else $error("error alone");
  chk_mcast_match: assert property (
    MCAST_VALID |-> MCAST_POINTS == POINT_STATE) else $error("frame data");
  chk_owned_conn: assert property (
    !OWNER_CONN [*4] |-> !OWNED) else $error("owned no link");
  chk_close_owned: assert property (CONN_CLOSE |-> !OWNED) else $error("owned at close");
  chk_config_hold: assert property (
    $fell(CONFIGURED) |-> $past(CONN_CLOSE)) else $error("config lost");
  chk_fault_cause: assert property (
    NVM_FAULT [*8] |-> MCAST_STATUS[ST_CAUSE_LO+:2] == CAUSE_NVM) else $error("cause");
endmodule

bind idf_top idf_asserts #(.NPTS(NPTS)) chk_u (.SYS_CLK, .RESET_N, .PSEL, .PENABLE,
  .PREADY, .PSLVERR, .OWNER_CONN, .NVM_FAULT, .POINT_STATE, .MCAST_VALID,
  .MCAST_POINTS, .MCAST_STATUS, .CONFIGURED, .OWNED, .CONN_CLOSE);

// ===== bench/idf_ctrl_model.sv
`timescale 1ns/100ps
module idf_ctrl_model (
  // link and frames
  input wire logic clk,
  input wire logic link_up,
  input wire logic edits_pending,
  input wire logic mcast_valid,
  output logic owner_conn,
  output logic reset_ok,
  output int frames
);
  always @(posedge clk) begin
    owner_conn <= link_up;
    frames <= mcast_valid ? frames + 1 : frames;
  end
  initial frames = 0;
  assign reset_ok = !edits_pending;
endmodule

// ===== bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import idf_pkg::*;
  logic SYS_CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, err;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic PREADY, PSLVERR, OWNER_CONN, NVM_FAULT = 0, BKPL_FAULT = 0, reset_ok;
  logic MCAST_VALID, CONFIGURED, OWNED, CONN_CLOSE, IRQ, link_up = 1, pend = 1;
  logic [15:0] IN_RAW, POINT_STATE, MCAST_POINTS, exp_pts, mask;
  logic [5:0] MCAST_STATUS;
  int fail_count = 0, tests_run = 0, frames, pt, lim, n;
  // 25 MHz clock
  always #20 SYS_CLK = ~SYS_CLK;
  idf_top dut_u (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .IN_RAW, .OWNER_CONN, .NVM_FAULT, .BKPL_FAULT,
    .POINT_STATE, .MCAST_VALID, .MCAST_POINTS, .MCAST_STATUS, .CONFIGURED,
    .OWNED, .CONN_CLOSE, .IRQ);
  idf_ctrl_model ctrl_u (.clk(SYS_CLK), .link_up, .edits_pending(pend),
    .mcast_valid(MCAST_VALID), .owner_conn(OWNER_CONN), .reset_ok, .frames);
  // compare and count
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge SYS_CLK);
  endtask
  // one transfer; an edge passes first so strobes never change twice at once
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    n = 0;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1 && ++n < 50);
    fail_count += (n >= 50);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  function automatic logic [31:0] st_exp(logic c, logic o, logic nv, logic bk);
    return {26'h0, nv ? CAUSE_NVM : bk ? CAUSE_BKPL : CAUSE_NONE, bk, nv, o, c};
  endfunction
  // move the point, check it waits the whole time, then the event and stamp
  task automatic step(logic v, int lm);
    logic [31:0] t0;
    apb(0, OFS_TIME, 0);
    t0 = rd;
    IN_RAW[pt] <= v;
    cyc(lm * TICK_CYCLES - 4);
    chk(POINT_STATE, exp_pts);
    exp_pts[pt] = v;
    cyc(TICK_CYCLES + 12);
    chk(POINT_STATE, exp_pts);
    chk(IRQ, mask[pt]);
    apb(0, OFS_INT_STATUS, 0);
    chk(rd, 32'h1 << pt);
    apb(0, OFS_TS_BASE + 8'(4 * pt), 0);
    chk(32'(rd - t0 >= lm && rd - t0 <= lm + 2), 1);
    apb(1, OFS_INT_STATUS, 32'h1 << pt);
  endtask
  // watchdog: the tests take under 1500 cycles
  initial begin
    cyc(20000);
    fail_count++;
    end_sim;
  end
  initial begin
    void'($urandom(71122));
    IN_RAW = 16'($urandom);
    exp_pts = IN_RAW;
    cyc(8);
    RESET_N <= 1;
    cyc(8);
    chk(POINT_STATE, exp_pts);
    apb(0, 8'h3c, 0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1, OFS_CTRL, 32'h1);
    // zero filter time takes the next sample
    pt = $urandom % 16;
    exp_pts[pt] = !exp_pts[pt];
    IN_RAW[pt] <= exp_pts[pt];
    cyc(7);
    chk(POINT_STATE, exp_pts);
    apb(0, OFS_POINTS, 0);
    chk(rd, {16'h0, exp_pts});
    apb(1, OFS_INT_STATUS, 32'hffff);
    repeat (3) begin
      pt = $urandom % 16;
      lim = 1 + $urandom % 3;
      mask = 16'($urandom);
      apb(1, OFS_FILT_BASE + 8'(4 * pt), {16'(lim + 1), 16'(lim)});
      apb(1, OFS_INT_MASK, {16'h0, mask});
      apb(0, OFS_INT_MASK, 0);
      chk(rd, {16'h0, mask});
      IN_RAW[pt] <= !exp_pts[pt];
      cyc(lim * TICK_CYCLES - 5);
      IN_RAW[pt] <= exp_pts[pt];
      cyc(60);
      chk(POINT_STATE, exp_pts);
      apb(0, OFS_INT_STATUS, 0);
      chk(rd, 0);
      // off-to-on waits lim, on-to-off waits lim + 1
      step(!exp_pts[pt], exp_pts[pt] ? lim + 1 : lim);
      step(!exp_pts[pt], exp_pts[pt] ? lim + 1 : lim);
    end
    // fault pins and link state reach status and frames
    for (int i = 0; i < 3; i++) begin
      {NVM_FAULT, BKPL_FAULT} <= 2'(3 - i);
      link_up <= i[0];
      cyc(12);
      apb(0, OFS_STATUS, 0);
      chk(rd, st_exp(1, i[0], i < 2, i != 1));
      chk(MCAST_STATUS, st_exp(1, i[0], i < 2, i != 1));
      chk(OWNED, i[0]);
    end
    {NVM_FAULT, BKPL_FAULT} <= 2'b00;
    link_up <= 1;
    pend <= 0;
    cyc(10);
    chk(reset_ok, 1);
    apb(1, OFS_CTRL, 32'h2);
    for (n = 0; CONN_CLOSE !== 1'b1 && n < 20; n++) @(posedge SYS_CLK);
    chk(CONN_CLOSE, 1);
    cyc(10);
    chk(CONFIGURED, 0);
    apb(0, OFS_FILT_BASE + 8'(4 * pt), 0);
    chk(rd, FILT_RESET);
    chk(32'(frames > 0), 1);
    end_sim;
  end
endmodule
